// file: rtl/ffmd_core.sv
// Purpose: Freefall/motion detection with debounce and source flags.
// Assumes: One sample_valid pulse per output sample; single clock.
// Notes:   Register read data appears one cycle after the read strobe.
// Notes on behaviour
// (RULE1) Combine bit 0 freefall, 1 motion.
// (RULE2) All axis enables zero disables detection.
// (RULE3) Latch and combine bits give four modes.
// (RULE4) Unlatched freefall sets flag after debounce completes.
// (RULE5) Counter mode 0 decrements; clears after delay.
// (RULE6) Counter mode 1 clears flag when condition ends.
// (RULE7) Unlatched freefall: source read keeps flag.
// (RULE8) Unlatched axis flags follow live enabled status.
// (RULE9) Latched freefall flag holds until source read.
// (RULE10) Latched read clears flag and counter.
// (RULE11) Latched axis flags freeze until source read.
// (RULE12) Unlatched motion: set after debounce, mode clears.
// (RULE13) Unlatched motion: read clears nothing.
// (RULE14) Latched motion: read clears source and counter.
// (RULE15) Latched motion holds axis flags until read.
// (RULE16) Only enabled axes enter evaluation.
// (RULE17) Config layout; low three bits read zero.
// (RULE18) Motion above threshold, freefall at or below.
// (RULE19) Unsigned seven-bit threshold compare.
// (RULE20) Polarity 0 positive, 1 negative.
// (RULE21) Counter mode bit in threshold register, reset 0.
// (RULE22) Counter advances once per sample while true.
`timescale 1ns/1ps
`default_nettype none
module ffmd_core import ffmd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Acceleration samples
  input wire logic sample_valid,
  input wire ffmd_axes_t sample,
  // Register port
  input wire ffmd_req_t req,
  output var logic [7:0] reg_rdata_q,
  // Status
  output var logic event_active_q
);
  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] ths_q;
  logic [7:0] lim_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] cnt_base;
  logic [5:0] flags_q;
  logic [5:0] live;
  logic [2:0] en;
  logic [2:0] high;
  logic [2:0] pol;
  logic event_latch_enable;
  logic combine_select;
  logic counter_mode_bit;
  logic any_en;
  logic cond;
  logic src_rd;
  logic src_clr;
  logic hit;
  logic ul_clr;
  logic event_active_d;
  logic frozen;
  ffmd_acc_t [2:0] acc;

  assign event_latch_enable = cfg_q[CFG_LATCH];
  assign combine_select = cfg_q[CFG_COMB];
  assign en = cfg_q[CFG_EN_HI:CFG_EN_LO];
  assign counter_mode_bit = ths_q[THS_MODE];
  assign acc = sample;
  assign src_rd = req.rd && (req.addr == ADDR_SRC);
  // Only a latched read has side effects; unlatched reads are passive
  assign src_clr = src_rd && event_latch_enable; // see (RULE7) see (RULE13)

  // ----------------------------------------------------------------
  // Per-axis compare
  // ----------------------------------------------------------------
  // Magnitude of -128 is 128, which still fits the 8-bit compare
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [7:0] mag;
    assign mag = acc[i][7] ? (~acc[i] + ONE8) : acc[i];
    assign high[i] = en[i] && (mag > {1'b0, ths_q[THS_HI:0]}); // see (RULE18) see (RULE19)
    assign pol[i] = en[i] && acc[i][7]; // see (RULE20)
    assign live[2*i+1] = high[i]; // see (RULE16)
    assign live[2*i] = pol[i];
  end

  // Combine enabled axes: OR of highs, or AND of lows
  assign any_en = |en; // see (RULE2)
  assign cond = any_en && (combine_select ? |high : ~|(high & en)); // see (RULE1) see (RULE3)

  // ----------------------------------------------------------------
  // Debounce counter
  // ----------------------------------------------------------------
  // A latched read restarts the count, so a new event waits the delay
  always_comb begin
    cnt_base = src_clr ? ZERO8 : cnt_q; // see (RULE10) see (RULE14)
    cnt_d = cnt_base;
    if (!any_en) begin
      cnt_d = ZERO8;
    end else if (sample_valid) begin
      if (cond) begin
        if (cnt_base < lim_q) begin
          cnt_d = cnt_base + ONE8; // see (RULE22)
        end
      end else if (counter_mode_bit) begin
        cnt_d = ZERO8; // see (RULE6)
      end else if (cnt_base != ZERO8) begin
        cnt_d = cnt_base - ONE8; // see (RULE5)
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_q <= ZERO8;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Event-active flag
  // ----------------------------------------------------------------
  assign hit = sample_valid && cond && (cnt_d == lim_q); // see (RULE4) see (RULE12)
  assign ul_clr = sample_valid && !cond && (cnt_d == ZERO8); // see (RULE5) see (RULE6)

  // A set in the same cycle as a clearing read wins
  always_comb begin
    if (!any_en) begin
      event_active_d = 1'b0;
    end else if (event_latch_enable) begin
      event_active_d = hit || (event_active_q && !src_clr); // see (RULE9) see (RULE14)
    end else begin
      event_active_d = hit || (event_active_q && !ul_clr); // see (RULE12)
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      event_active_q <= 1'b0;
    end else begin
      event_active_q <= event_active_d;
    end
  end

  // ----------------------------------------------------------------
  // Axis flags
  // ----------------------------------------------------------------
  // Frozen once a latched event is raised; the raising sample is kept
  assign frozen = event_latch_enable && event_active_q && !src_clr; // see (RULE11) see (RULE15)

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flags_q <= ZERO6;
    end else if (!any_en) begin
      flags_q <= ZERO6;
    end else if (frozen) begin
      flags_q <= flags_q;
    end else if (sample_valid) begin
      flags_q <= live; // see (RULE8)
    end else if (src_clr) begin
      flags_q <= ZERO6; // see (RULE14)
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_q <= RST_CFG;
    end else if (req.wr && req.addr == ADDR_CFG) begin
      cfg_q <= req.wdata & CFG_WMASK; // see (RULE17)
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ths_q <= RST_THS; // see (RULE21)
    end else if (req.wr && req.addr == ADDR_THS) begin
      ths_q <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lim_q <= RST_CNT;
    end else if (req.wr && req.addr == ADDR_CNT) begin
      lim_q <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Disabled axes read zero even if their stored flags lag a config change
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata_q <= ZERO8;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_CFG: reg_rdata_q <= cfg_q;
        ADDR_SRC: reg_rdata_q <= {event_active_q, 1'b0,
                                  flags_q & {{2{en[2]}}, {2{en[1]}}, {2{en[0]}}}};
        ADDR_THS: reg_rdata_q <= ths_q;
        ADDR_CNT: reg_rdata_q <= lim_q;
        default: reg_rdata_q <= ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Single-cycle qualifiers; the checks join them with sequence and
  sequence s_src_read;
    src_rd && !sample_valid;
  endsequence

  sequence s_sample_true;
    sample_valid && cond;
  endsequence

  sequence s_sample_false;
    sample_valid && !cond;
  endsequence

  sequence s_latched_event;
    event_latch_enable && any_en && event_active_q;
  endsequence

  // Register port and disable
  chk_cfg_low_zero: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE17)
    req.rd && req.addr == ADDR_CFG |=> reg_rdata_q[2:0] == 3'h0)
    else $error("config low bits not zero");
  chk_disabled_idle: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE2)
    !any_en |=> !event_active_q && flags_q == ZERO6)
    else $error("disabled detector shows event");
  chk_disabled_count: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE2)
    !any_en |=> cnt_q == ZERO8)
    else $error("disabled detector kept a count");

  // Disabled axes read zero whatever is stored; sign alone picks polarity
  for (genvar k = 0; k < 3; k++) begin : g_axis_chk
    chk_axis_masked: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE16)
      req.rd && req.addr == ADDR_SRC && !en[k] |=> reg_rdata_q[2*k+1 -: 2] == 2'h0)
      else $error("disabled axis flags read nonzero");
    chk_axis_pol: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE20)
      !event_latch_enable && en[k] && sample_valid
        |=> flags_q[2*k] == $past($signed(acc[k]) < 0))
      else $error("axis polarity does not follow sign");
  end

  // Debounce counter
  chk_count_step: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE22)
    (any_en && !src_clr && cnt_q < lim_q) and s_sample_true
      |=> cnt_q == $past(cnt_q) + ONE8)
    else $error("debounce count did not advance");
  chk_count_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE22)
    any_en && !sample_valid && !src_clr |=> $stable(cnt_q))
    else $error("debounce count moved without a sample");
  chk_mode0_step: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE5)
    (any_en && !counter_mode_bit && !src_clr && cnt_q != ZERO8) and s_sample_false
      |=> cnt_q == $past(cnt_q) - ONE8)
    else $error("mode 0 count did not step down");
  chk_mode1_zero: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE6)
    (any_en && counter_mode_bit) and s_sample_false |=> cnt_q == ZERO8)
    else $error("mode 1 count not cleared");

  // Event-active flag: set only by a finished count, cleared per mode
  chk_count_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE4)
    any_en && sample_valid && cond && cnt_d == lim_q |=> event_active_q ##0 cnt_q == $past(lim_q))
    else $error("debounce complete but no event");
  chk_no_early_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE4)
    any_en && !event_active_q && !(sample_valid && cond && cnt_d == lim_q)
      |=> !event_active_q)
    else $error("event raised before debounce completed");
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE9)
    s_latched_event and !src_rd |=> event_active_q)
    else $error("latched event dropped without read");
  chk_read_clears: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE10)
    event_latch_enable and s_src_read |=> !event_active_q && cnt_q == ZERO8)
    else $error("latched read did not clear");
  chk_read_passive: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE13)
    ((!event_latch_enable && any_en) and s_src_read) ##0 $stable(cfg_q)
      |=> $stable(event_active_q) && $stable(cnt_q))
    else $error("unlatched read changed state");
  chk_unlatched_keep: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE7)
    !event_latch_enable && any_en && event_active_q && !sample_valid |=> event_active_q)
    else $error("unlatched event dropped without a sample");
  chk_mode0_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE5)
    (!event_latch_enable && !counter_mode_bit && any_en && event_active_q && cnt_q > ONE8)
      and s_sample_false |=> event_active_q)
    else $error("mode 0 event dropped before delay");
  chk_mode1_clear: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE6)
    (!event_latch_enable && counter_mode_bit) and s_sample_false |=> !event_active_q)
    else $error("flag kept after condition ended");

  // Axis flags
  chk_src_flag_clr: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE14)
    event_latch_enable and s_src_read |=> flags_q == ZERO6)
    else $error("latched read left axis flags");
  chk_flags_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE15)
    s_latched_event and !src_rd |=> $stable(flags_q))
    else $error("latched flags moved");
  chk_flags_live: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE8)
    !event_latch_enable && any_en && sample_valid |=> flags_q == $past(live))
    else $error("unlatched flags not live");
endmodule // ffmd_core
`default_nettype wire

// file: rtl/ffmd_pkg.sv
// Purpose: Shared constants and types for the freefall/motion detector.
// Assumes: 8-bit register port, signed 8-bit axis samples.
// Notes:   Axis index 2 is Z, 1 is Y, 0 is X throughout.
package ffmd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h15;
  localparam logic [7:0] ADDR_SRC = 8'h16;
  localparam logic [7:0] ADDR_THS = 8'h17;
  localparam logic [7:0] ADDR_CNT = 8'h18;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_THS = 8'h00;
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [5:0] ZERO6 = 6'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_LATCH = 7;
  localparam int CFG_COMB = 6;
  localparam int CFG_EN_HI = 5;
  localparam int CFG_EN_LO = 3;
  localparam logic [7:0] CFG_WMASK = 8'hF8;
  localparam int THS_MODE = 7;
  localparam int THS_HI = 6;
  localparam int SRC_EVENT = 7;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic signed [7:0] ffmd_acc_t;
  typedef struct packed {
    ffmd_acc_t z;
    ffmd_acc_t y;
    ffmd_acc_t x;
  } ffmd_axes_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ffmd_req_t;
endpackage

// file: dv/ffmd_host_model.sv
// Purpose: Host model issuing register reads and writes to the detector.
// Assumes: Read data is valid one cycle after the read strobe edge.
// Notes:   Between accesses address and data carry the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module ffmd_host_model import ffmd_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Register port
  output var ffmd_req_t req,
  input wire logic [7:0] reg_rdata_q
);
  initial req = '0;
  // One strobe edge, then release so a stale bus never looks valid
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk_sys);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // Read: data lands at the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    acc(a, 1'b0, ZERO8);
    #1 d = reg_rdata_q;
  endtask
endmodule // ffmd_host_model
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the freefall/motion detector.
// Assumes: Host model owns the register port; bench owns the samples.
// Notes:   Each scenario after t_regs first disables detection to start from clear state.
`timescale 1ns/1ps
`default_nettype none
module tb import ffmd_pkg::*; ();
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic sample_valid = 1'b0;
  ffmd_axes_t sample = '0;
  ffmd_req_t req;
  logic [7:0] reg_rdata_q;
  logic event_active_q;
  logic [7:0] d;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  ffmd_core ffmd_core_i (.clk_sys(clk_sys), .reset_n(reset_n), .sample_valid(sample_valid),
    .sample(sample), .req(req), .reg_rdata_q(reg_rdata_q), .event_active_q(event_active_q));
  ffmd_host_model ffmd_host_model_i (.clk_sys(clk_sys), .req(req), .reg_rdata_q(reg_rdata_q));
  // Hang guard, well above the 130 or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    ffmd_host_model_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic chk_event(input logic e);
    chk({7'h00, event_active_q}, {7'h00, e});
  endtask
  // Disable first: clears counter and flags left by the previous scenario
  task automatic setup(input logic [7:0] cfg, input logic [7:0] ths, input logic [7:0] cnt);
    ffmd_host_model_i.acc(ADDR_CFG, 1'b1, ZERO8);
    ffmd_host_model_i.acc(ADDR_THS, 1'b1, ths);
    ffmd_host_model_i.acc(ADDR_CNT, 1'b1, cnt);
    ffmd_host_model_i.acc(ADDR_CFG, 1'b1, cfg);
  endtask
  // One sample pulse; outputs are looked at after the taking edge settles
  task automatic smp(input ffmd_acc_t z, input ffmd_acc_t y, input ffmd_acc_t x);
    @(posedge clk_sys);
    sample <= '{z: z, y: y, x: x};
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    sample <= ~{z, y, x};
    #1;
  endtask
  task automatic finish_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped read and config masking
  task automatic t_regs();
    rdchk(ADDR_CFG, 8'h00);
    rdchk(ADDR_THS, 8'h00);
    rdchk(ADDR_SRC, 8'h00);
    rdchk(8'h20, 8'h00);
    ffmd_host_model_i.acc(ADDR_CFG, 1'b1, 8'hFF);
    rdchk(ADDR_CFG, 8'hF8);
    ffmd_host_model_i.acc(ADDR_THS, 1'b1, 8'h85);
    rdchk(ADDR_THS, 8'h85);
  endtask
  // Freefall, unlatched, counter mode 0
  task automatic t_ff_live();
    setup(8'h38, 8'h10, 8'h02);
    smp(8'h00, 8'h00, 8'h10);
    chk_event(1'b0);
    smp(8'h00, 8'h10, 8'h00);
    chk_event(1'b1);
    rdchk(ADDR_SRC, 8'h80);
    chk_event(1'b1);
    smp(8'h11, 8'h00, 8'h00);
    chk_event(1'b1);
    smp(8'h11, 8'h00, 8'h00);
    chk_event(1'b0);
  endtask
  // Freefall, unlatched, counter mode 1
  task automatic t_ff_clear();
    setup(8'h38, 8'h90, 8'h02);
    smp(8'h00, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    chk_event(1'b1);
    smp(8'h00, 8'h00, 8'h20);
    chk_event(1'b0);
    smp(8'h00, 8'h00, 8'h00);
    chk_event(1'b0);
  endtask
  // Freefall, latched: flags frozen, read clears, count restarts from zero
  task automatic t_ff_latch();
    setup(8'hB8, 8'h10, 8'h01);
    smp(8'h00, 8'h00, 8'h00);
    smp(8'h40, 8'h00, 8'h00);
    chk_event(1'b1);
    rdchk(ADDR_SRC, 8'h80);
    chk_event(1'b0);
    smp(8'h00, 8'h00, 8'h00);
    chk_event(1'b1);
  endtask
  // Motion, latched
  task automatic t_mo_latch();
    setup(8'hF8, 8'h10, 8'h01);
    smp(8'h00, 8'h20, 8'hC0);
    smp(8'h00, 8'h00, 8'h00);
    chk_event(1'b1);
    rdchk(ADDR_SRC, 8'h8B);
    chk_event(1'b0);
    rdchk(ADDR_SRC, 8'h00);
  endtask
  // Motion, unlatched, X only, counter mode 0 with a zero count
  task automatic t_mo_live();
    setup(8'h48, 8'h10, 8'h00);
    smp(8'h00, 8'hB0, 8'h7F);
    chk_event(1'b1);
    rdchk(ADDR_SRC, 8'h82);
    chk_event(1'b1);
    smp(8'h00, 8'h00, 8'h00);
    chk_event(1'b0);
  endtask
  // Motion, unlatched, counter mode 1: the flag drops when high-g ends
  task automatic t_mo_clear();
    setup(8'h48, 8'h90, 8'h01);
    smp(8'h00, 8'h00, 8'h20);
    chk_event(1'b1);
    rdchk(ADDR_SRC, 8'h82);
    smp(8'h00, 8'h00, 8'h00);
    chk_event(1'b0);
  endtask
  // All axes off: nothing is detected
  task automatic t_off();
    setup(8'h40, 8'h10, 8'h00);
    smp(8'h7F, 8'h7F, 8'h7F);
    chk_event(1'b0);
    rdchk(ADDR_SRC, 8'h00);
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_ff_live();
    t_ff_clear();
    t_ff_latch();
    t_mo_latch();
    t_mo_live();
    t_mo_clear();
    t_off();
    finish_test();
  end
endmodule // tb
`default_nettype wire
